// ### logic/ast_regs.svh
`ifndef AST_REGS_SVH
`define AST_REGS_SVH
`define AST_ADR_MODE 8'h00
`define AST_ADR_STAT 8'h04
`define AST_ADR_BAUD 8'h08
`define AST_ADR_TXD 8'h0C
`define AST_ADR_RXD 8'h10
`define AST_ADR_FLAG 8'h14
`define AST_MODE_TXE 7
`define AST_MODE_RXE 6
`define AST_MODE_CL 3
`define AST_MODE_SL 2
`define AST_MODE_WMASK 8'hFC
`define AST_MODE_RST 8'h00
`define AST_BAUD_RST 4'h0
`define AST_BAUD_EXT 4'h8
`define AST_ERR_PE 2
`define AST_ERR_FE 1
`define AST_ERR_OVE 0
`define AST_FLAG_TXDONE 0
`define AST_OVS 16
`define AST_HALF 8
`endif

// ### logic/ast_pkg.sv
package ast_pkg;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD = 2'h2,
    PAR_EVEN = 2'h3
  } ast_par_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2,
    TX_PAR = 3'h3, TX_STOP1 = 3'h4, TX_STOP2 = 3'h5
  } ast_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2,
    RX_PAR = 3'h3, RX_STOP = 3'h4
  } ast_rx_st_t;
  typedef struct packed {
    logic cyc; logic stb; logic we;
    logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;
  } ast_wb_req_t;
  typedef struct packed {
    logic ack; logic [31:0] dat;
  } ast_wb_rsp_t;
  typedef struct packed {
    logic [7:0] mode; logic [3:0] baud; logic [7:0] pre; logic ext_q;
    ast_tx_st_t tst; logic [3:0] tcnt; logic [2:0] tbit; logic [7:0] tsh;
    logic tpar; logic txd; logic tflag; logic tirq;
    ast_rx_st_t rst; logic [3:0] rcnt; logic [2:0] rbit; logic [7:0] rsh;
    logic rpar; logic [7:0] rbuf; logic [2:0] rerr; logic rfull; logic rirq;
    logic ack; logic [31:0] dat;
  } ast_state_t;
endpackage

// ### logic/ast_uart.sv
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "ast_regs.svh"
module ast_uart #(
  parameter int OVS = `AST_OVS,
  parameter int HALF = `AST_HALF
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire ast_pkg::ast_wb_req_t wb_req, // Wishbone request
  output var ast_pkg::ast_wb_rsp_t wb_rsp, // Wishbone answer
  input wire logic serial_rx_pin, // Serial data in
  input wire logic ext_baud_clock_pin, // External 16x clock
  output logic serial_tx_pin, // Serial data out
  output logic tx_done_irq, // Transmit done pulse
  output logic rx_done_irq // Receive done pulse
);
  ast_pkg::ast_state_t s_q;
  ast_pkg::ast_state_t s_d;
  ast_pkg::ast_par_t par;
  logic [3:0] n;
  logic [7:0] mask;
  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic char8;
  logic [7:0] tdat;
  logic traw;
  logic tpar_new;
  logic tx_load;
  logic rdone;
  logic pe;
  logic [2:0] tlast;

  assign par = ast_pkg::ast_par_t'(s_q.mode[5:4]);
  assign char8 = s_q.mode[`AST_MODE_CL];
  assign tlast = char8 ? 3'h7 : 3'h6;
  // A sixteenth-bit tick every 2^n cycles, n = select + 1.
  assign n = s_q.baud + 4'h1;
  assign mask = 8'hFF >> (4'h8 - n);
  always_comb begin
    if (s_q.baud == `AST_BAUD_EXT) begin
      tick = ext_baud_clock_pin & ~s_q.ext_q;
    end else if (s_q.baud < `AST_BAUD_EXT) begin
      tick = (s_q.pre & mask) == mask;
    end else begin
      tick = 1'b0;
    end
  end

  assign acc = wb_req.cyc & wb_req.stb & ~s_q.ack;
  assign wr = acc & wb_req.we & wb_req.sel[0];
  assign rd = acc & ~wb_req.we;
  // With a 7-bit character, bit 7 is dropped before it can reach the line.
  assign tdat = char8 ? wb_req.dat[7:0] : {1'b0, wb_req.dat[6:0]};
  assign traw = ^tdat;
  always_comb begin
    unique case (par)
      ast_pkg::PAR_EVEN: tpar_new = traw;
      ast_pkg::PAR_ODD: tpar_new = ~traw;
      ast_pkg::PAR_ZERO: tpar_new = 1'b0;
      ast_pkg::PAR_NONE: tpar_new = 1'b0;
    endcase
  end
  assign tx_load = wr && wb_req.adr == `AST_ADR_TXD &&
    s_q.mode[`AST_MODE_TXE] && s_q.tst == ast_pkg::TX_IDLE;
  assign rdone = s_q.mode[`AST_MODE_RXE] && s_q.rst == ast_pkg::RX_STOP &&
    tick && s_q.rcnt == 4'(OVS - 1);
  always_comb begin
    unique case (par)
      ast_pkg::PAR_EVEN: pe = ^{s_q.rsh, s_q.rpar};
      ast_pkg::PAR_ODD: pe = ~^{s_q.rsh, s_q.rpar};
      ast_pkg::PAR_ZERO: pe = 1'b0;
      ast_pkg::PAR_NONE: pe = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.pre = s_q.pre + 8'h01;
    s_d.ext_q = ext_baud_clock_pin;
    s_d.tirq = 1'b0;
    s_d.rirq = 1'b0;
    s_d.ack = acc;
    s_d.dat = 32'h0;
    if (wr) begin
      unique case (wb_req.adr)
        `AST_ADR_MODE: s_d.mode = wb_req.dat[7:0] & `AST_MODE_WMASK;
        `AST_ADR_BAUD: s_d.baud = wb_req.dat[7:4];
        `AST_ADR_FLAG: begin
          if (wb_req.dat[`AST_FLAG_TXDONE]) begin
            s_d.tflag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (wb_req.adr)
        `AST_ADR_MODE: s_d.dat = {24'h0, s_q.mode};
        `AST_ADR_STAT: s_d.dat = {29'h0, s_q.rerr};
        `AST_ADR_BAUD: s_d.dat = {24'h0, s_q.baud, 4'h0};
        `AST_ADR_RXD: begin
          s_d.dat = {24'h0, s_q.rbuf};
          s_d.rerr = 3'h0;
          s_d.rfull = 1'b0;
        end
        `AST_ADR_FLAG: begin
          s_d.dat = {29'h0, s_q.tst != ast_pkg::TX_IDLE, s_q.rfull, s_q.tflag};
        end
        default: s_d.dat = 32'h0;
      endcase
    end

    // Transmitter; each bit lasts OVS ticks.
    if (!s_q.mode[`AST_MODE_TXE]) begin
      s_d.tst = ast_pkg::TX_IDLE;
      s_d.txd = 1'b1;
    end else begin
      unique case (s_q.tst)
        ast_pkg::TX_IDLE: begin
          if (tx_load) begin
            s_d.tst = ast_pkg::TX_START;
            s_d.tsh = tdat;
            s_d.tpar = tpar_new;
            s_d.tcnt = 4'h0;
            s_d.txd = 1'b0;
          end
        end
        default: begin
          if (tick) begin
            s_d.tcnt = s_q.tcnt + 4'h1;
            if (s_q.tcnt == 4'(OVS - 1)) begin
              s_d.tcnt = 4'h0;
              unique case (s_q.tst)
                ast_pkg::TX_START: begin
                  s_d.tst = ast_pkg::TX_DATA;
                  s_d.tbit = 3'h0;
                  s_d.txd = s_q.tsh[0];
                end
                ast_pkg::TX_DATA: begin
                  s_d.tsh = s_q.tsh >> 1;
                  s_d.tbit = s_q.tbit + 3'h1;
                  s_d.txd = s_q.tsh[1];
                  if (s_q.tbit == tlast) begin
                    if (par == ast_pkg::PAR_NONE) begin
                      s_d.tst = ast_pkg::TX_STOP1;
                      s_d.txd = 1'b1;
                    end else begin
                      s_d.tst = ast_pkg::TX_PAR;
                      s_d.txd = s_q.tpar;
                    end
                  end
                end
                ast_pkg::TX_PAR: begin
                  s_d.tst = ast_pkg::TX_STOP1;
                  s_d.txd = 1'b1;
                end
                ast_pkg::TX_STOP1: begin
                  if (s_q.mode[`AST_MODE_SL]) begin
                    s_d.tst = ast_pkg::TX_STOP2;
                  end else begin
                    s_d.tst = ast_pkg::TX_IDLE;
                    s_d.tirq = 1'b1;
                    s_d.tflag = 1'b1;
                  end
                end
                default: begin
                  s_d.tst = ast_pkg::TX_IDLE;
                  s_d.txd = 1'b1;
                  s_d.tirq = 1'b1;
                  s_d.tflag = 1'b1;
                end
              endcase
            end
          end
        end
      endcase
    end

    // Receiver; an abort leaves buffer and status exactly as they were.
    if (!s_q.mode[`AST_MODE_RXE]) begin
      s_d.rst = ast_pkg::RX_IDLE;
    end else if (tick) begin
      s_d.rcnt = s_q.rcnt + 4'h1;
      unique case (s_q.rst)
        ast_pkg::RX_IDLE: begin
          if (!serial_rx_pin) begin
            s_d.rst = ast_pkg::RX_START;
            s_d.rcnt = 4'h0;
          end
        end
        ast_pkg::RX_START: begin
          if (s_q.rcnt == 4'(HALF - 1)) begin
            s_d.rcnt = 4'h0;
            s_d.rbit = 3'h0;
            s_d.rsh = 8'h00;
            s_d.rst = serial_rx_pin ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
          end
        end
        ast_pkg::RX_DATA: begin
          if (s_q.rcnt == 4'(OVS - 1)) begin
            s_d.rcnt = 4'h0;
            s_d.rsh[s_q.rbit] = serial_rx_pin;
            s_d.rbit = s_q.rbit + 3'h1;
            if (s_q.rbit == tlast) begin
              s_d.rst = (par == ast_pkg::PAR_NONE) ?
                ast_pkg::RX_STOP : ast_pkg::RX_PAR;
            end
          end
        end
        ast_pkg::RX_PAR: begin
          if (s_q.rcnt == 4'(OVS - 1)) begin
            s_d.rcnt = 4'h0;
            s_d.rpar = serial_rx_pin;
            s_d.rst = ast_pkg::RX_STOP;
          end
        end
        ast_pkg::RX_STOP: begin
          // Only the first stop bit is looked at.
          if (rdone) begin
            s_d.rst = ast_pkg::RX_IDLE;
            s_d.rbuf = s_q.rsh;
            s_d.rirq = 1'b1;
            s_d.rfull = 1'b1;
            s_d.rerr[`AST_ERR_PE] = pe;
            s_d.rerr[`AST_ERR_FE] = ~serial_rx_pin;
            s_d.rerr[`AST_ERR_OVE] = s_q.rfull && !(rd && wb_req.adr == `AST_ADR_RXD);
          end
        end
        default: s_d.rst = ast_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp = {s_q.ack, s_q.dat};
  assign serial_tx_pin = s_q.txd;
  assign tx_done_irq = s_q.tirq;
  assign rx_done_irq = s_q.rirq;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  tx_start_a: assert property (tx_load |=> s_q.tst == ast_pkg::TX_START && !serial_tx_pin)
    else $error("transmit did not start");
  tx_idle_a: assert property (s_q.tst == ast_pkg::TX_IDLE |-> serial_tx_pin)
    else $error("idle line not high");
  tx_done_a: assert property (tx_done_irq |-> s_q.tflag && s_q.tst == ast_pkg::TX_IDLE)
    else $error("done event without flag");
  tx_parity_a: assert property (tx_load |=> s_q.tpar ==
    (par == ast_pkg::PAR_EVEN ? ^s_q.tsh : par == ast_pkg::PAR_ODD ? ~^s_q.tsh : 1'b0))
    else $error("parity bit wrong");
  rx_short_a: assert property (rx_done_irq && !char8 |-> !s_q.rbuf[7])
    else $error("bit 7 not zero");
  // A buffer read may still clear status while receive is off.
  rx_abort_a: assert property (!s_q.mode[`AST_MODE_RXE] &&
    !(rd && wb_req.adr == `AST_ADR_RXD) |=>
    !rx_done_irq && $stable(s_q.rbuf) && $stable(s_q.rerr))
    else $error("abort changed state");
  rx_frame_a: assert property (rdone |=> rx_done_irq && s_q.rfull &&
    s_q.rerr[`AST_ERR_FE] == !$past(serial_rx_pin))
    else $error("frame end wrong");
  rx_clear_a: assert property (rd && wb_req.adr == `AST_ADR_RXD && !rdone |=>
    s_q.rerr == 3'h0 && !s_q.rfull)
    else $error("read did not clear");
  rx_nocheck_a: assert property (rx_done_irq && !par[1] |-> !s_q.rerr[`AST_ERR_PE])
    else $error("parity flagged unchecked");
  rx_false_a: assert property (s_q.rst == ast_pkg::RX_START && tick &&
    s_q.rcnt == 4'(HALF - 1) && serial_rx_pin && s_q.mode[`AST_MODE_RXE]
    |=> s_q.rst == ast_pkg::RX_IDLE)
    else $error("glitch taken as start");
  tx_short_a: assert property (tx_load && !char8 |=> !s_q.tsh[7])
    else $error("bit 7 reached the shifter");
  tx_nopar_a: assert property (par == ast_pkg::PAR_NONE &&
    s_q.tst == ast_pkg::TX_DATA |=> s_q.tst != ast_pkg::TX_PAR)
    else $error("parity slot without parity");
  tx_stop_a: assert property (s_q.tst == ast_pkg::TX_STOP1 ||
    s_q.tst == ast_pkg::TX_STOP2 |-> serial_tx_pin)
    else $error("stop bit not high");
  tx_gate_a: assert property (!s_q.mode[`AST_MODE_TXE] |=>
    s_q.tst == ast_pkg::TX_IDLE && serial_tx_pin)
    else $error("transmit not stopped");
  rx_gate_a: assert property (!s_q.mode[`AST_MODE_RXE] |=> s_q.rst == ast_pkg::RX_IDLE)
    else $error("receive not stopped");
  // A frame that ends in the cycle of a buffer read is not an overrun.
  rx_load_a: assert property (rdone && !(rd && wb_req.adr == `AST_ADR_RXD) |=>
    s_q.rbuf == $past(s_q.rsh) && s_q.rerr[`AST_ERR_OVE] == $past(s_q.rfull))
    else $error("buffer not loaded");
  tx_done_c: cover property (tx_done_irq);
  rx_fe_c: cover property (rx_done_irq && s_q.rerr[`AST_ERR_FE]);
  tx_two_c: cover property (s_q.tst == ast_pkg::TX_STOP2);
  rx_err_c: cover property (rx_done_irq && s_q.rerr[`AST_ERR_PE]);
  rx_ovr_c: cover property (rx_done_irq && s_q.rerr[`AST_ERR_OVE]);
endmodule
`default_nettype wire

// ### tb/ast_far.sv
`timescale 1ns/10ps
`default_nettype none
module ast_far #(
  parameter int BIT = 32
) (
  input wire logic ref_clk, // Bench clock
  input wire logic line_in, // Device transmit line
  output logic line_out // Device receive line
);
  initial line_out = 1'b1;
  // Frames come laid out start bit first; the line is left high afterwards.
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      line_out <= bits[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    line_out <= 1'b1;
  endtask
  // Samples at bit centres, counted from the falling start edge.
  task automatic grab(input int n, output logic [11:0] bits);
    int k;
    k = 0;
    bits = '1;
    while (line_in !== 1'b0 && k < 4000) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_in;
      repeat (BIT) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ast_regs.svh"
module tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_clk = 1'b0;
  logic rx_line;
  logic tx_line;
  logic tx_irq;
  logic rx_irq;
  ast_pkg::ast_wb_req_t wb_req = '0;
  ast_pkg::ast_wb_rsp_t wb_rsp;
  int bad_count = 0;
  int check_count = 0;
  int ntx = 0;
  int nrx = 0;
  int cyc_n = 0;
  int fn;
  logic [11:0] fb;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ext_clk <= ~ext_clk;
  ast_uart ast_uart_inst (.ref_clk(ref_clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .serial_rx_pin(rx_line), .ext_baud_clock_pin(ext_clk), .serial_tx_pin(tx_line),
    .tx_done_irq(tx_irq), .rx_done_irq(rx_irq));
  ast_far ast_far_inst (.ref_clk(ref_clk), .line_in(tx_line), .line_out(rx_line));
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (tx_irq === 1'b1) ntx <= ntx + 1;
    if (rx_irq === 1'b1) nrx <= nrx + 1;
    if (cyc_n == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A wait that runs out counts against the run like any mismatch.
  task automatic late(input logic ok, input int k);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h after %h cycles", $time, ok, 1'b1, k);
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The request is held until ack is seen high at a rising edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 50);
    q = wb_rsp.dat;
    late(wb_rsp.ack === 1'b1, k);
    wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_irq(input bit rx, input int n);
    int k;
    k = 0;
    while ((rx ? nrx : ntx) < n && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    late((rx ? nrx : ntx) >= n, k);
  endtask
  task automatic mk(input logic [7:0] d, input logic [1:0] p, input logic cl, input logic sl,
    input logic badp, input logic badst);
    logic [7:0] m;
    m = cl ? d : {1'b0, d[6:0]};
    fb = '0;
    fn = 1;
    for (int i = 0; i < 7 + cl; i++) begin
      fb[fn] = m[i];
      fn++;
    end
    if (p != 2'h0) begin
      fb[fn] = (p == 2'h3 ? ^m : p == 2'h2 ? ~^m : 1'b0) ^ badp;
      fn++;
    end
    fb[fn] = ~badst;
    fn++;
    if (sl) begin
      fb[fn] = 1'b1;
      fn++;
    end
  endtask
  task automatic t_reset();
    chk({31'h0, tx_line}, 32'h1);
    expect_rd(`AST_ADR_MODE, 32'h0);
    expect_rd(`AST_ADR_STAT, 32'h0);
    expect_rd(`AST_ADR_BAUD, 32'h0);
    expect_rd(`AST_ADR_FLAG, 32'h0);
    wr(8'h20, 32'hFF);
    expect_rd(8'h20, 32'h0);
    wr(`AST_ADR_MODE, 32'hFF);
    expect_rd(`AST_ADR_MODE, 32'hFC);
    wr(`AST_ADR_MODE, 32'h0);
    wr(`AST_ADR_TXD, 32'h55);
    repeat (100) @(posedge ref_clk);
    chk({31'h0, tx_line}, 32'h1);
    chk(32'(ntx), 32'h0);
  endtask
  task automatic t_tx();
    logic [11:0] got;
    logic [11:0] msk;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 8'hB5 ^ 8'(i);
      // The mode is rewritten only while the line is idle.
      wr(`AST_ADR_MODE, {24'h0, 2'b10, 2'(i), 1'(i), 1'(i >> 1), 2'b00});
      wr(`AST_ADR_TXD, {24'h0, d});
      mk(d, 2'(i), 1'(i), 1'(i >> 1), 1'b0, 1'b0);
      ast_far_inst.grab(fn, got);
      msk = (12'h001 << fn) - 12'h001;
      chk({20'h0, got & msk}, {20'h0, fb});
      wait_irq(1'b0, i + 1);
      chk(32'(ntx), 32'(i + 1));
      expect_rd(`AST_ADR_FLAG, 32'h1);
      wr(`AST_ADR_FLAG, 32'h1);
      expect_rd(`AST_ADR_FLAG, 32'h0);
    end
  endtask
  task automatic t_rx();
    logic [7:0] d;
    logic [31:0] e;
    int n;
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 2; b++) begin
        d = 8'hC3 ^ 8'(i);
        // The frame is already counted when send returns, so count from before it.
        n = nrx;
        wr(`AST_ADR_MODE, {24'h0, 2'b01, 2'(i), 1'(i + 1), 1'(i >> 1), 2'b00});
        mk(d, 2'(i), 1'(i + 1), 1'b0, 1'(b), 1'b0);
        ast_far_inst.send(fb, fn);
        wait_irq(1'b1, n + 1);
        e = (b == 1 && i >= 2) ? 32'h4 : 32'h0;
        expect_rd(`AST_ADR_STAT, e);
        e = {24'h0, d & {1'(i + 1), 7'h7F}};
        expect_rd(`AST_ADR_RXD, e);
        expect_rd(`AST_ADR_STAT, 32'h0);
      end
    end
  endtask
  task automatic t_err();
    int n;
    n = nrx;
    wr(`AST_ADR_MODE, 32'h48);
    mk(8'h5A, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    ast_far_inst.send(fb, fn);
    wait_irq(1'b1, n + 1);
    expect_rd(`AST_ADR_STAT, 32'h2);
    mk(8'h22, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    ast_far_inst.send(fb, fn);
    wait_irq(1'b1, n + 2);
    chk(32'(nrx), 32'(n + 2));
    expect_rd(`AST_ADR_STAT, 32'h1);
    expect_rd(`AST_ADR_RXD, 32'h22);
    expect_rd(`AST_ADR_STAT, 32'h0);
  endtask
  // Receive enable is dropped mid-frame; nothing may change afterwards.
  task automatic t_abort();
    int n;
    n = nrx;
    mk(8'h99, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    fork
      ast_far_inst.send(fb, fn);
      begin
        repeat (120) @(posedge ref_clk);
        wr(`AST_ADR_MODE, 32'h08);
      end
    join
    repeat (100) @(posedge ref_clk);
    chk(32'(nrx), 32'(n));
    // Receive is switched back on so the buffer is read while enabled.
    wr(`AST_ADR_MODE, 32'h48);
    expect_rd(`AST_ADR_RXD, 32'h22);
    expect_rd(`AST_ADR_STAT, 32'h0);
  endtask
  // The external baud input toggles every clock, so one tick per two clocks.
  task automatic t_ext();
    int n;
    n = nrx;
    wr(`AST_ADR_BAUD, 32'h80);
    expect_rd(`AST_ADR_BAUD, 32'h80);
    wr(`AST_ADR_MODE, 32'h78);
    mk(8'hA7, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0);
    ast_far_inst.send(fb, fn);
    wait_irq(1'b1, n + 1);
    expect_rd(`AST_ADR_STAT, 32'h0);
    expect_rd(`AST_ADR_RXD, 32'hA7);
    wr(`AST_ADR_BAUD, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_abort();
    t_ext();
    wrap_up();
  end
endmodule
`default_nettype wire
